/* File: include/pirq_map.svh */
// Offsets, field slots, masks and reset values of the priority registers.
// Included by its bare name; definitions only.
`ifndef PIRQ_MAP_SVH
`define PIRQ_MAP_SVH

// Register indices; byte address is four times the index
`define PIRQ_IDX_THREE 3'h3
`define PIRQ_IDX_FOUR  3'h4
`define PIRQ_IDX_FIVE  3'h5
`define PIRQ_IDX_SIX   3'h6

// Writable and readable bits; all other bits are reserved
`define PIRQ_MASK_THREE 16'h000c
`define PIRQ_MASK_FOUR  16'hfc3f
`define PIRQ_MASK_FIVE  16'hff3f
`define PIRQ_MASK_SIX   16'hffcf

`define PIRQ_CFG_RESET 16'h0000

// Field codes and decoded levels
`define PIRQ_CODE_OFF 2'h0
`define PIRQ_CODE_L0  2'h1
`define PIRQ_CODE_L1  2'h2
`define PIRQ_CODE_L2  2'h3
`define PIRQ_LEVEL_0  2'h0
`define PIRQ_LEVEL_1  2'h1
`define PIRQ_LEVEL_2  2'h2

// Field slots: slot k is bits 2k+1..2k
`define PIRQ_SLOT_CAN_BUS_OFF   1
`define PIRQ_SLOT_SP0_RX_FULL   7
`define PIRQ_SLOT_SP1_TX_EMPTY  6
`define PIRQ_SLOT_SP1_RX_FULL   5
`define PIRQ_SLOT_PORT_A        2
`define PIRQ_SLOT_PORT_B        1
`define PIRQ_SLOT_PORT_C        0
`define PIRQ_SLOT_DEC1_INDEX    7
`define PIRQ_SLOT_DEC1_HOME     6
`define PIRQ_SLOT_SC1_RX_FULL   5
`define PIRQ_SLOT_SC1_RX_ERROR  4
`define PIRQ_SLOT_SC1_TX_IDLE   2
`define PIRQ_SLOT_SC1_TX_EMPTY  1
`define PIRQ_SLOT_SP0_TX_EMPTY  0
`define PIRQ_SLOT_TIMER_C0      7
`define PIRQ_SLOT_TIMER_D3      6
`define PIRQ_SLOT_TIMER_D2      5
`define PIRQ_SLOT_TIMER_D1      4
`define PIRQ_SLOT_TIMER_D0      3
`define PIRQ_SLOT_DEC0_INDEX    1
`define PIRQ_SLOT_DEC0_HOME     0

`endif

/* File: include/pirq_pkg.sv */
// Types shared by the priority register bank.
// Stands alone; compiled before the modules.
package pirq_pkg;

  typedef enum logic {
    PIRQ_IDLE,
    PIRQ_ANSWER
  } pirq_phase_type;

  typedef struct packed {
    pirq_phase_type   phase;
    logic [31:0]      rdata;
    logic [3:0][15:0] cfg;
    logic [3:0][7:0]  en;
    logic [3:0][15:0] lvl;
  } pirq_state_type;

endpackage : pirq_pkg

/* File: logic/pirq_wmerge.sv */
// Write merge of one 16-bit priority register.
// Assumes the caller qualifies the write strobe with the bus handshake.
module pirq_wmerge (
  // Current value and write request
  input  wire logic [15:0] cur,
  input  wire logic [15:0] wdata,
  input  wire logic [1:0]  be,
  input  wire logic        wr,
  input  wire logic [15:0] mask,
  // Next value
  output logic      [15:0] next_value
);

  logic [15:0] merged;

  always_comb begin
    merged = cur;
    if (wr && be[0]) begin
      merged[7:0] = wdata[7:0];
    end
    if (wr && be[1]) begin
      merged[15:8] = wdata[15:8];
    end
    // Reserved bits never store a written one
    next_value = merged & mask;
  end

endmodule : pirq_wmerge

/* File: logic/pirq_decode.sv */
// Decodes the eight 2-bit fields of one register into enable and level.
// Clears reserved slots itself by ANDing the value with the mask input.
`include "pirq_map.svh"

module pirq_decode (
  // Register value
  input  wire logic [15:0] cfg,
  input  wire logic [15:0] mask,
  // Per-slot result
  output logic      [7:0]  en,
  output logic      [15:0] lvl
);

  function automatic logic [2:0] decode_level(input logic [1:0] code);
    case (code)
      `PIRQ_CODE_L0:  decode_level = {1'b1, `PIRQ_LEVEL_0};
      `PIRQ_CODE_L1:  decode_level = {1'b1, `PIRQ_LEVEL_1};
      `PIRQ_CODE_L2:  decode_level = {1'b1, `PIRQ_LEVEL_2};
      default:        decode_level = {1'b0, `PIRQ_LEVEL_0};
    endcase
  endfunction : decode_level

  logic [15:0] live;
  logic [2:0]  res;

  always_comb begin
    live = cfg & mask;
    en   = 8'h00;
    lvl  = 16'h0000;
    res  = 3'h0;
    for (int k = 0; k < 8; k++) begin
      res          = decode_level(live[2*k +: 2]);
      en[k]        = res[2];
      lvl[2*k +: 2] = res[1:0];
    end
  end

endmodule : pirq_decode

/* File: logic/pirq_regs.sv */
// Interrupt priority register bank, three to six, with decoded outputs.
// Assumes an Avalon-MM master on SYS_CLK and arbitration logic downstream.
// What this block does
// - Field code 01 gives level 0, 10 gives level 1 and 11 gives level 2.
// - Code 00 disables the source, and every field is 00 after reset.
// - No source can be given a level above 2.
// - Reserved bits read as zero and ignore writes.
// - Register three holds the CAN bus-off field in bits 3-2, bits 1-0 reserved.
// - Register four holds SP0 rx-full, SP1 tx-empty and SP1 rx-full in 15-10.
// - Register four reserves bits 9-6 and holds ports A, B, C in bits 5-0.
// - Register five holds decoder 1 index, home, SC1 rx-full, rx-error in 15-8.
// - Register five reserves 7-6, holds SC1 idle, SC1 empty, SP0 empty in 5-0.
// - Register six holds timer C0 and timer D3, D2, D1, D0 in bits 15-6.
// - Register six reserves 5-4, holds decoder 0 index and home in 3-0.
`include "pirq_map.svh"

module pirq_regs (
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  // Avalon-MM slave
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Register three
  output logic             CAN_BUS_OFF_EN,
  output logic      [1:0]  CAN_BUS_OFF_LEVEL,
  // Register four
  output logic             SP0_RX_FULL_EN,
  output logic      [1:0]  SP0_RX_FULL_LEVEL,
  output logic             SP1_TX_EMPTY_EN,
  output logic      [1:0]  SP1_TX_EMPTY_LEVEL,
  output logic             SP1_RX_FULL_EN,
  output logic      [1:0]  SP1_RX_FULL_LEVEL,
  output logic             PORT_A_PIN_EN,
  output logic      [1:0]  PORT_A_PIN_LEVEL,
  output logic             PORT_B_PIN_EN,
  output logic      [1:0]  PORT_B_PIN_LEVEL,
  output logic             PORT_C_PIN_EN,
  output logic      [1:0]  PORT_C_PIN_LEVEL,
  // Register five
  output logic             DECODER1_INDEX_EN,
  output logic      [1:0]  DECODER1_INDEX_LEVEL,
  output logic             DECODER1_HOME_WDOG_EN,
  output logic      [1:0]  DECODER1_HOME_WDOG_LEVEL,
  output logic             SC1_RX_FULL_EN,
  output logic      [1:0]  SC1_RX_FULL_LEVEL,
  output logic             SC1_RX_ERROR_EN,
  output logic      [1:0]  SC1_RX_ERROR_LEVEL,
  output logic             SC1_TX_IDLE_EN,
  output logic      [1:0]  SC1_TX_IDLE_LEVEL,
  output logic             SC1_TX_EMPTY_EN,
  output logic      [1:0]  SC1_TX_EMPTY_LEVEL,
  output logic             SP0_TX_EMPTY_EN,
  output logic      [1:0]  SP0_TX_EMPTY_LEVEL,
  // Register six
  output logic             TIMER_C_CH0_EN,
  output logic      [1:0]  TIMER_C_CH0_LEVEL,
  output logic             TIMER_D_CH3_EN,
  output logic      [1:0]  TIMER_D_CH3_LEVEL,
  output logic             TIMER_D_CH2_EN,
  output logic      [1:0]  TIMER_D_CH2_LEVEL,
  output logic             TIMER_D_CH1_EN,
  output logic      [1:0]  TIMER_D_CH1_LEVEL,
  output logic             TIMER_D_CH0_EN,
  output logic      [1:0]  TIMER_D_CH0_LEVEL,
  output logic             DECODER0_INDEX_EN,
  output logic      [1:0]  DECODER0_INDEX_LEVEL,
  output logic             DECODER0_HOME_WDOG_EN,
  output logic      [1:0]  DECODER0_HOME_WDOG_LEVEL
);

  pirq_pkg::pirq_state_type st;
  pirq_pkg::pirq_state_type next_st;

  logic             req;
  logic [2:0]       idx;
  logic             commit;
  logic [3:0]       wr_sel;
  logic [3:0][15:0] next_cfg;
  logic [3:0][7:0]  next_en;
  logic [3:0][15:0] next_lvl;

  // Unmapped indices read as zero
  function automatic logic [15:0] read_value(
    input logic [2:0]       ri,
    input logic [3:0][15:0] cfg
  );
    case (ri)
      `PIRQ_IDX_THREE: read_value = cfg[0] & `PIRQ_MASK_THREE;
      `PIRQ_IDX_FOUR:  read_value = cfg[1] & `PIRQ_MASK_FOUR;
      `PIRQ_IDX_FIVE:  read_value = cfg[2] & `PIRQ_MASK_FIVE;
      `PIRQ_IDX_SIX:   read_value = cfg[3] & `PIRQ_MASK_SIX;
      default:         read_value = 16'h0000;
    endcase
  endfunction : read_value

  assign req    = AVS_READ | AVS_WRITE;
  assign idx    = AVS_ADDRESS[4:2];
  // Write lands only at the edge where waitrequest is seen low
  assign commit = AVS_WRITE & (st.phase == pirq_pkg::PIRQ_ANSWER);

  assign wr_sel[0] = commit & (idx == `PIRQ_IDX_THREE);
  assign wr_sel[1] = commit & (idx == `PIRQ_IDX_FOUR);
  assign wr_sel[2] = commit & (idx == `PIRQ_IDX_FIVE);
  assign wr_sel[3] = commit & (idx == `PIRQ_IDX_SIX);

  // One wait state: simple decode, no combinational read path to the bus
  assign AVS_WAITREQUEST = req & (st.phase != pirq_pkg::PIRQ_ANSWER);
  assign AVS_READDATA    = st.rdata;

  pirq_wmerge u_merge_three (
    .cur        (st.cfg[0]),
    .wdata      (AVS_WRITEDATA[15:0]),
    .be         (AVS_BYTEENABLE[1:0]),
    .wr         (wr_sel[0]),
    .mask       (`PIRQ_MASK_THREE),
    .next_value (next_cfg[0])
  );

  pirq_wmerge u_merge_four (
    .cur        (st.cfg[1]),
    .wdata      (AVS_WRITEDATA[15:0]),
    .be         (AVS_BYTEENABLE[1:0]),
    .wr         (wr_sel[1]),
    .mask       (`PIRQ_MASK_FOUR),
    .next_value (next_cfg[1])
  );

  pirq_wmerge u_merge_five (
    .cur        (st.cfg[2]),
    .wdata      (AVS_WRITEDATA[15:0]),
    .be         (AVS_BYTEENABLE[1:0]),
    .wr         (wr_sel[2]),
    .mask       (`PIRQ_MASK_FIVE),
    .next_value (next_cfg[2])
  );

  pirq_wmerge u_merge_six (
    .cur        (st.cfg[3]),
    .wdata      (AVS_WRITEDATA[15:0]),
    .be         (AVS_BYTEENABLE[1:0]),
    .wr         (wr_sel[3]),
    .mask       (`PIRQ_MASK_SIX),
    .next_value (next_cfg[3])
  );

  // Decoding the next value keeps outputs in step with the register
  pirq_decode u_dec_three (
    .cfg  (next_cfg[0]),
    .mask (`PIRQ_MASK_THREE),
    .en   (next_en[0]),
    .lvl  (next_lvl[0])
  );

  pirq_decode u_dec_four (
    .cfg  (next_cfg[1]),
    .mask (`PIRQ_MASK_FOUR),
    .en   (next_en[1]),
    .lvl  (next_lvl[1])
  );

  pirq_decode u_dec_five (
    .cfg  (next_cfg[2]),
    .mask (`PIRQ_MASK_FIVE),
    .en   (next_en[2]),
    .lvl  (next_lvl[2])
  );

  pirq_decode u_dec_six (
    .cfg  (next_cfg[3]),
    .mask (`PIRQ_MASK_SIX),
    .en   (next_en[3]),
    .lvl  (next_lvl[3])
  );

  always_comb begin
    next_st = st;
    case (st.phase)
      pirq_pkg::PIRQ_IDLE: begin
        if (req) begin
          next_st.phase = pirq_pkg::PIRQ_ANSWER;
          next_st.rdata = {16'h0000, read_value(idx, st.cfg)};
        end
      end
      pirq_pkg::PIRQ_ANSWER: begin
        next_st.phase = pirq_pkg::PIRQ_IDLE;
      end
      default: begin
        next_st.phase = pirq_pkg::PIRQ_IDLE;
      end
    endcase
    next_st.cfg = next_cfg;
    next_st.en  = next_en;
    next_st.lvl = next_lvl;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      st.phase <= pirq_pkg::PIRQ_IDLE;
      st.rdata <= 32'h00000000;
      st.cfg   <= {4{`PIRQ_CFG_RESET}};
      st.en    <= 32'h00000000;
      st.lvl   <= 64'h0000000000000000;
    end else begin
      st <= next_st;
    end
  end

  // Register three
  assign CAN_BUS_OFF_EN    = st.en[0][`PIRQ_SLOT_CAN_BUS_OFF];
  assign CAN_BUS_OFF_LEVEL = st.lvl[0][2*`PIRQ_SLOT_CAN_BUS_OFF +: 2];

  // Register four
  assign SP0_RX_FULL_EN     = st.en[1][`PIRQ_SLOT_SP0_RX_FULL];
  assign SP0_RX_FULL_LEVEL  = st.lvl[1][2*`PIRQ_SLOT_SP0_RX_FULL +: 2];
  assign SP1_TX_EMPTY_EN    = st.en[1][`PIRQ_SLOT_SP1_TX_EMPTY];
  assign SP1_TX_EMPTY_LEVEL = st.lvl[1][2*`PIRQ_SLOT_SP1_TX_EMPTY +: 2];
  assign SP1_RX_FULL_EN     = st.en[1][`PIRQ_SLOT_SP1_RX_FULL];
  assign SP1_RX_FULL_LEVEL  = st.lvl[1][2*`PIRQ_SLOT_SP1_RX_FULL +: 2];
  assign PORT_A_PIN_EN      = st.en[1][`PIRQ_SLOT_PORT_A];
  assign PORT_A_PIN_LEVEL   = st.lvl[1][2*`PIRQ_SLOT_PORT_A +: 2];
  assign PORT_B_PIN_EN      = st.en[1][`PIRQ_SLOT_PORT_B];
  assign PORT_B_PIN_LEVEL   = st.lvl[1][2*`PIRQ_SLOT_PORT_B +: 2];
  assign PORT_C_PIN_EN      = st.en[1][`PIRQ_SLOT_PORT_C];
  assign PORT_C_PIN_LEVEL   = st.lvl[1][2*`PIRQ_SLOT_PORT_C +: 2];

  // Register five
  assign DECODER1_INDEX_EN        = st.en[2][`PIRQ_SLOT_DEC1_INDEX];
  assign DECODER1_INDEX_LEVEL     = st.lvl[2][2*`PIRQ_SLOT_DEC1_INDEX +: 2];
  assign DECODER1_HOME_WDOG_EN    = st.en[2][`PIRQ_SLOT_DEC1_HOME];
  assign DECODER1_HOME_WDOG_LEVEL = st.lvl[2][2*`PIRQ_SLOT_DEC1_HOME +: 2];
  assign SC1_RX_FULL_EN           = st.en[2][`PIRQ_SLOT_SC1_RX_FULL];
  assign SC1_RX_FULL_LEVEL        = st.lvl[2][2*`PIRQ_SLOT_SC1_RX_FULL +: 2];
  assign SC1_RX_ERROR_EN          = st.en[2][`PIRQ_SLOT_SC1_RX_ERROR];
  assign SC1_RX_ERROR_LEVEL       = st.lvl[2][2*`PIRQ_SLOT_SC1_RX_ERROR +: 2];
  assign SC1_TX_IDLE_EN           = st.en[2][`PIRQ_SLOT_SC1_TX_IDLE];
  assign SC1_TX_IDLE_LEVEL        = st.lvl[2][2*`PIRQ_SLOT_SC1_TX_IDLE +: 2];
  assign SC1_TX_EMPTY_EN          = st.en[2][`PIRQ_SLOT_SC1_TX_EMPTY];
  assign SC1_TX_EMPTY_LEVEL       = st.lvl[2][2*`PIRQ_SLOT_SC1_TX_EMPTY +: 2];
  assign SP0_TX_EMPTY_EN          = st.en[2][`PIRQ_SLOT_SP0_TX_EMPTY];
  assign SP0_TX_EMPTY_LEVEL       = st.lvl[2][2*`PIRQ_SLOT_SP0_TX_EMPTY +: 2];

  // Register six
  assign TIMER_C_CH0_EN           = st.en[3][`PIRQ_SLOT_TIMER_C0];
  assign TIMER_C_CH0_LEVEL        = st.lvl[3][2*`PIRQ_SLOT_TIMER_C0 +: 2];
  assign TIMER_D_CH3_EN           = st.en[3][`PIRQ_SLOT_TIMER_D3];
  assign TIMER_D_CH3_LEVEL        = st.lvl[3][2*`PIRQ_SLOT_TIMER_D3 +: 2];
  assign TIMER_D_CH2_EN           = st.en[3][`PIRQ_SLOT_TIMER_D2];
  assign TIMER_D_CH2_LEVEL        = st.lvl[3][2*`PIRQ_SLOT_TIMER_D2 +: 2];
  assign TIMER_D_CH1_EN           = st.en[3][`PIRQ_SLOT_TIMER_D1];
  assign TIMER_D_CH1_LEVEL        = st.lvl[3][2*`PIRQ_SLOT_TIMER_D1 +: 2];
  assign TIMER_D_CH0_EN           = st.en[3][`PIRQ_SLOT_TIMER_D0];
  assign TIMER_D_CH0_LEVEL        = st.lvl[3][2*`PIRQ_SLOT_TIMER_D0 +: 2];
  assign DECODER0_INDEX_EN        = st.en[3][`PIRQ_SLOT_DEC0_INDEX];
  assign DECODER0_INDEX_LEVEL     = st.lvl[3][2*`PIRQ_SLOT_DEC0_INDEX +: 2];
  assign DECODER0_HOME_WDOG_EN    = st.en[3][`PIRQ_SLOT_DEC0_HOME];
  assign DECODER0_HOME_WDOG_LEVEL = st.lvl[3][2*`PIRQ_SLOT_DEC0_HOME +: 2];

endmodule : pirq_regs

/* File: tb/pirq_regs_monitor.sv */
// Concurrent checks on the priority register bank ports, bound below.
// Assumes one clock, synchronous active-low reset and a contract-keeping master.
module pirq_regs_monitor (
  // Clock and reset
  input wire logic        SYS_CLK,
  input wire logic        RST_N,
  // Bus
  input wire logic [4:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  // Sampled sources
  input wire logic        CAN_BUS_OFF_EN,
  input wire logic [1:0]  CAN_BUS_OFF_LEVEL,
  input wire logic        PORT_C_PIN_EN,
  input wire logic [1:0]  PORT_C_PIN_LEVEL,
  input wire logic [1:0]  TIMER_D_CH0_LEVEL
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        acc;
  logic [15:0] wd_q;
  assign acc = AVS_WRITE && !AVS_WAITREQUEST;
  // Previous write data, so no part-select has to pass through $past
  always_ff @(posedge SYS_CLK) begin
    wd_q <= AVS_WRITEDATA[15:0];
  end
  function automatic logic [1:0] lvl_of(input logic [1:0] c);
    return (c == 2'h0) ? 2'h0 : c - 2'h1;
  endfunction : lvl_of
  default clocking mc @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  wait_one_a : assert property (
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("Request not answered after one wait state");
  idle_ready_a : assert property (!(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST)
    else $error("Wait request raised with no request");
  upper_zero_a : assert property (AVS_READDATA[31:16] == 16'h0000)
    else $error("Upper read data not zero");
  level_cap_a : assert property (
    CAN_BUS_OFF_LEVEL != 2'h3 && PORT_C_PIN_LEVEL != 2'h3 && TIMER_D_CH0_LEVEL != 2'h3)
    else $error("Level above two");
  off_zero_a : assert property (!CAN_BUS_OFF_EN |-> CAN_BUS_OFF_LEVEL == 2'h0)
    else $error("Disabled source shows a level");
  reset_off_a : assert property ($rose(RST_N) |-> !CAN_BUS_OFF_EN && !PORT_C_PIN_EN)
    else $error("Source enabled after reset");
  can_commit_a : assert property (
    acc && AVS_ADDRESS[4:2] == 3'h3 && AVS_BYTEENABLE[0] |=>
    CAN_BUS_OFF_EN == (wd_q[3:2] != 2'h0) && CAN_BUS_OFF_LEVEL == lvl_of(wd_q[3:2]))
    else $error("Bus-off field decode wrong after write");
  portc_commit_a : assert property (
    acc && AVS_ADDRESS[4:2] == 3'h4 && AVS_BYTEENABLE[0] |=>
    PORT_C_PIN_EN == (wd_q[1:0] != 2'h0) && PORT_C_PIN_LEVEL == lvl_of(wd_q[1:0]))
    else $error("Port C field decode wrong after write");
  hold_out_a : assert property (
    !acc |=> $stable(CAN_BUS_OFF_EN) && $stable(PORT_C_PIN_LEVEL))
    else $error("Output moved without a write");
  rd_three_a : assert property (
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[4:2] == 3'h3 |->
    (AVS_READDATA[15:0] & 16'hfff3) == 16'h0000)
    else $error("Reserved bits of register three read nonzero");
  cover property (acc && AVS_ADDRESS[4:2] == 3'h3);
  cover property (AVS_READ && !AVS_WAITREQUEST);
  cover property (CAN_BUS_OFF_LEVEL == 2'h2);
endmodule : pirq_regs_monitor

bind pirq_regs pirq_regs_monitor mon (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .CAN_BUS_OFF_EN(CAN_BUS_OFF_EN), .CAN_BUS_OFF_LEVEL(CAN_BUS_OFF_LEVEL),
  .PORT_C_PIN_EN(PORT_C_PIN_EN), .PORT_C_PIN_LEVEL(PORT_C_PIN_LEVEL),
  .TIMER_D_CH0_LEVEL(TIMER_D_CH0_LEVEL));

/* File: tb/pirq_arb_model.sv */
// Behavioural arbitration model fed by the decoded priority outputs.
// Assumes reserved slots arrive already forced to zero.
module pirq_arb_model (
  // Four registers of eight slots each
  input  wire logic [31:0] src_en,
  input  wire logic [63:0] src_lvl,
  // Highest level among enabled sources
  output logic             any_on,
  output logic      [1:0]  top_level
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    any_on    = |src_en;
    top_level = 2'h0;
    for (int k = 0; k < 32; k++) begin
      // Disabled sources never compete, whatever their level shows
      if (src_en[k] && src_lvl[2*k +: 2] > top_level) begin
        top_level = src_lvl[2*k +: 2];
      end
    end
  end
endmodule : pirq_arb_model

/* File: tb/testbench.sv */
// Directed bench for the priority register bank with an arbiter model.
// Assumes one wait state per access and outputs valid the cycle after a write.
`include "pirq_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK = 1'b0, RST_N = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0, AVS_WAITREQUEST;
  logic [4:0]  AVS_ADDRESS = 5'h00;
  logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, rd;
  logic [3:0]  AVS_BYTEENABLE = 4'h0;
  logic        any_on;
  logic [1:0]  top_lvl;
  // Slot k of register r; reserved slots tied low and masked off
  wire [3:0][7:0]  en_v;
  wire [3:0][15:0] lv_v;
  assign en_v[0][0]    = 1'b0;
  assign en_v[0][7:2]  = 6'h00;
  assign en_v[1][4:3]  = 2'h0;
  assign en_v[2][3]    = 1'b0;
  assign en_v[3][2]    = 1'b0;
  assign lv_v[0][1:0]  = 2'h0;
  assign lv_v[0][15:4] = 12'h000;
  assign lv_v[1][9:6]  = 4'h0;
  assign lv_v[2][7:6]  = 2'h0;
  assign lv_v[3][5:4]  = 2'h0;
  logic [15:0] mk [4] = '{`PIRQ_MASK_THREE, `PIRQ_MASK_FOUR, `PIRQ_MASK_FIVE, `PIRQ_MASK_SIX};
  logic [15:0] pats [6] = '{16'hffff, 16'he4e4, 16'h1b1b, 16'h4e4e, 16'hb1b1, 16'h0000};
  logic [2:0]  holes [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
  int miscompares = 0;
  int total_checks = 0;

  pirq_regs uut (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .CAN_BUS_OFF_EN(en_v[0][1]), .CAN_BUS_OFF_LEVEL(lv_v[0][3:2]),
    .SP0_RX_FULL_EN(en_v[1][7]), .SP0_RX_FULL_LEVEL(lv_v[1][15:14]),
    .SP1_TX_EMPTY_EN(en_v[1][6]), .SP1_TX_EMPTY_LEVEL(lv_v[1][13:12]),
    .SP1_RX_FULL_EN(en_v[1][5]), .SP1_RX_FULL_LEVEL(lv_v[1][11:10]),
    .PORT_A_PIN_EN(en_v[1][2]), .PORT_A_PIN_LEVEL(lv_v[1][5:4]),
    .PORT_B_PIN_EN(en_v[1][1]), .PORT_B_PIN_LEVEL(lv_v[1][3:2]),
    .PORT_C_PIN_EN(en_v[1][0]), .PORT_C_PIN_LEVEL(lv_v[1][1:0]),
    .DECODER1_INDEX_EN(en_v[2][7]), .DECODER1_INDEX_LEVEL(lv_v[2][15:14]),
    .DECODER1_HOME_WDOG_EN(en_v[2][6]), .DECODER1_HOME_WDOG_LEVEL(lv_v[2][13:12]),
    .SC1_RX_FULL_EN(en_v[2][5]), .SC1_RX_FULL_LEVEL(lv_v[2][11:10]),
    .SC1_RX_ERROR_EN(en_v[2][4]), .SC1_RX_ERROR_LEVEL(lv_v[2][9:8]),
    .SC1_TX_IDLE_EN(en_v[2][2]), .SC1_TX_IDLE_LEVEL(lv_v[2][5:4]),
    .SC1_TX_EMPTY_EN(en_v[2][1]), .SC1_TX_EMPTY_LEVEL(lv_v[2][3:2]),
    .SP0_TX_EMPTY_EN(en_v[2][0]), .SP0_TX_EMPTY_LEVEL(lv_v[2][1:0]),
    .TIMER_C_CH0_EN(en_v[3][7]), .TIMER_C_CH0_LEVEL(lv_v[3][15:14]),
    .TIMER_D_CH3_EN(en_v[3][6]), .TIMER_D_CH3_LEVEL(lv_v[3][13:12]),
    .TIMER_D_CH2_EN(en_v[3][5]), .TIMER_D_CH2_LEVEL(lv_v[3][11:10]),
    .TIMER_D_CH1_EN(en_v[3][4]), .TIMER_D_CH1_LEVEL(lv_v[3][9:8]),
    .TIMER_D_CH0_EN(en_v[3][3]), .TIMER_D_CH0_LEVEL(lv_v[3][7:6]),
    .DECODER0_INDEX_EN(en_v[3][1]), .DECODER0_INDEX_LEVEL(lv_v[3][3:2]),
    .DECODER0_HOME_WDOG_EN(en_v[3][0]), .DECODER0_HOME_WDOG_LEVEL(lv_v[3][1:0]));

  pirq_arb_model arb (
    .src_en(en_v & 32'hfbf7e702), .any_on(any_on), .top_level(top_lvl),
    .src_lvl(lv_v & {`PIRQ_MASK_SIX, `PIRQ_MASK_FIVE, `PIRQ_MASK_FOUR, `PIRQ_MASK_THREE}));

  initial begin
    forever #10 SYS_CLK = ~SYS_CLK;
  end

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp

  function automatic logic [7:0] exp_en(input logic [15:0] v);
    for (int k = 0; k < 8; k++) exp_en[k] = |v[2*k +: 2];
  endfunction : exp_en

  function automatic logic [15:0] exp_lv(input logic [15:0] v);
    for (int k = 0; k < 8; k++) exp_lv[2*k +: 2] = v[2*k +: 2] == 2'h0 ? 2'h0 : v[2*k +: 2] - 2'h1;
  endfunction : exp_lv

  // Holds the request until waitrequest is seen low, then releases it
  task automatic bus(input logic wr, input logic [2:0] idx, input logic [15:0] d,
                     input logic [1:0] be);
    int n;
    n = 0;
    @(posedge SYS_CLK);
    AVS_ADDRESS <= {idx, 2'b00};
    AVS_WRITEDATA <= {16'ha5a5, d};
    AVS_BYTEENABLE <= {2'b11, be};
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
    if (n >= 20) begin
      cmp(32'h1, 32'h0, "bus answer timeout");
      stop_test();
    end
    rd = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask : bus

  task automatic rdchk(input logic [2:0] idx, input logic [15:0] exp);
    bus(1'b0, idx, 16'h0000, 2'b11);
    cmp(rd, {16'h0000, exp}, "read data");
  endtask : rdchk

  task automatic outs(input int r, input logic [15:0] v);
    @(negedge SYS_CLK);
    cmp({24'h0, en_v[r] & exp_en(mk[r])}, {24'h0, exp_en(v & mk[r])}, "enables");
    cmp({16'h0, lv_v[r] & mk[r]}, {16'h0, exp_lv(v & mk[r])}, "levels");
  endtask : outs

  task automatic t_reset();
    for (int r = 0; r < 4; r++) begin
      rdchk(3'(r + 3), `PIRQ_CFG_RESET);
      outs(r, 16'h0000);
    end
  endtask : t_reset

  task automatic t_codes();
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, `PIRQ_IDX_THREE, 16'hfff3 | 16'(c << 2), 2'b11);
      outs(0, 16'(c << 2));
      cmp({30'h0, top_lvl}, (c == 0) ? 32'h0 : 32'(c - 1), "arbiter level");
      cmp({31'h0, any_on}, (c == 0) ? 32'h0 : 32'h1, "arbiter any");
      rdchk(`PIRQ_IDX_THREE, 16'(c << 2));
    end
  endtask : t_codes

  task automatic t_layout();
    for (int r = 1; r < 4; r++) begin
      foreach (pats[p]) begin
        bus(1'b1, 3'(r + 3), pats[p], 2'b11);
        outs(r, pats[p]);
        rdchk(3'(r + 3), pats[p] & mk[r]);
      end
    end
  endtask : t_layout

  task automatic t_bytes();
    bus(1'b1, `PIRQ_IDX_SIX, 16'hffff, 2'b01);
    rdchk(`PIRQ_IDX_SIX, 16'h00cf);
    bus(1'b1, `PIRQ_IDX_SIX, 16'h7a00, 2'b10);
    outs(3, 16'h7acf);
  endtask : t_bytes

  task automatic t_holes();
    foreach (holes[h]) begin
      bus(1'b1, holes[h], 16'hffff, 2'b11);
      rdchk(holes[h], 16'h0000);
    end
    rdchk(`PIRQ_IDX_SIX, 16'h7acf);
    rdchk(`PIRQ_IDX_THREE, 16'h000c);
  endtask : t_holes

  initial begin
    repeat (4) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    t_reset();
    t_codes();
    t_layout();
    t_bytes();
    t_holes();
    @(posedge SYS_CLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    t_reset();
    stop_test();
  end
endmodule : testbench
